/* inc/rlscan_pkg.sv */
// constants of the relay logic scan and trip latch
package rlscan_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned SYS_HZ = 10_000_000;
  localparam int unsigned POWER_HZ = 60;
  localparam int unsigned TICKS_PER_CYCLE = 8;
  localparam int unsigned TICK_CYC = SYS_HZ / (POWER_HZ * TICKS_PER_CYCLE);
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned N_TRIP = 3;
  localparam int unsigned N_VAR = 14;
  localparam int unsigned N_TMR = 10;
  localparam int unsigned N_SLOT = 9;
  localparam int unsigned N_EQ = 2 * N_TRIP + N_VAR;
  localparam int unsigned N_POINT = 250;
  localparam int unsigned EQ_SV0 = 2 * N_TRIP;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_LOCAL = 12'h004;
  localparam logic [11:0] OFS_REMOTE = 12'h008;
  localparam logic [11:0] OFS_TDUR = 12'h00c;
  localparam logic [11:0] OFS_STAT = 12'h010;
  localparam logic [11:0] OFS_PU = 12'h040;
  localparam logic [11:0] OFS_DO = 12'h080;
  localparam logic [11:0] OFS_EQ = 12'h400;
  // ----------------------------------------
  // equation slot fields
  // ----------------------------------------
  localparam int unsigned SLOT_EN = 10;
  localparam int unsigned SLOT_OR = 9;
  localparam int unsigned SLOT_INV = 8;
  // ----------------------------------------
  // reset values and answers
  // ----------------------------------------
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [7:0] SWITCH_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EVAL = 4'b0010,
    ST_TRIP = 4'b0100,
    ST_TIMR = 4'b1000
  } rlscan_state_type;
endpackage

/* design/rlscan_top.sv */
// relay logic scan engine with variable timers and latching trip channels
//
// Operation
// - at most nine operands per equation
// - operand space of 250 logic points
// - whole logic evaluated once each tick
// - point bits hold until next pass
// - fixed evaluation order, trips before variables
// - trip sees previous pass variable value
// - fourteen variables, ten with timers
// - timer pickup and dropout delays, zero allowed
// - true trip condition asserts trip output
// - duration timer starts on edge, no retrigger
// - trip follows condition beyond minimum duration
// - trip latched until timer, condition, unlatch clear
// - unlatch by equation, button or command
// - precedence inversion, then and, then or
//
// The address map and register access over AXI4-Lite were decided locally.
module rlscan_top
  import rlscan_pkg::*;
#(
  parameter int unsigned TICK_COUNT = TICK_CYC,
  parameter int unsigned ELEM_W = 64
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // axi4-lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // protection element bits and pins
  input wire logic [ELEM_W-1:0] elem_bits,
  input wire logic [1:0] opto_in,
  input wire logic target_btn,
  // logic point outputs
  output logic [N_TRIP-1:0] trip_output_bit,
  output logic [N_VAR-1:0] logic_variable,
  output logic [N_TMR-1:0] variable_timer_output
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ELEM_W < 1 || 47 + ELEM_W > N_POINT || TICK_COUNT < 256) begin : g_bad
    $error("rlscan_top: parameter out of range");
  end
  // ----------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [2:0] pin_f_r;
  logic btn_prev_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rst_sync_r <= 2'b00;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];
  // three stages; a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
      pin_f_r <= 3'h0;
      btn_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= {target_btn, opto_in};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      for (int i = 0; i < 3; i++) if (pin_s2_r[i] == pin_s3_r[i]) pin_f_r[i] <= pin_s3_r[i];
      btn_prev_r <= pin_f_r[2];
    end
  end
  // ----------------------------------------
  // register file state
  // ----------------------------------------
  logic [7:0] local_r, remote_r;
  logic [15:0] tdur_r;
  logic [15:0] pu_r [N_TMR];
  logic [15:0] do_r [N_TMR];
  logic [10:0] eq_mem [N_EQ*16];
  logic tgt_pend_r;
  rlscan_state_type st_r;
  // delay in sixteenths of a cycle to ticks, nearest tick
  function automatic logic [15:0] to_ticks(input logic [15:0] v);
    to_ticks = 16'((17'(v) + 17'd1) >> 1);
  endfunction
  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  logic aw_full_r, w_full_r, wr_go, wr_ok;
  logic [9:0] aw_word_r;
  logic [31:0] wdat_r;
  logic [3:0] wstb_r;
  logic [9:0] wr_eq;
  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_eq = aw_word_r - 10'(OFS_EQ >> 2);
  // hold address and data until both are present
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_word_r <= 10'h000;
      wdat_r <= 32'h0;
      wstb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_word_r <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdat_r <= s_axi_wdata;
        wstb_r <= s_axi_wstrb; // strobes travel with their data beat
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  // write decode; strobes of the low lane gate eight-bit fields
  always_comb begin
    wr_ok = 1'b1;
    if (aw_word_r >= 10'(OFS_EQ >> 2)) wr_ok = !wr_eq[9] && wr_eq[8:4] < 5'(N_EQ) && wr_eq[3:0] < 4'(N_SLOT);
    else if (aw_word_r == 10'(OFS_CTRL >> 2)) wr_ok = 1'b1;
    else if (aw_word_r == 10'(OFS_LOCAL >> 2)) wr_ok = 1'b1;
    else if (aw_word_r == 10'(OFS_REMOTE >> 2)) wr_ok = 1'b1;
    else if (aw_word_r == 10'(OFS_TDUR >> 2)) wr_ok = 1'b1;
    else if (aw_word_r == 10'(OFS_STAT >> 2)) wr_ok = 1'b1;
    else if (aw_word_r >= 10'(OFS_PU >> 2) && aw_word_r < 10'((OFS_PU >> 2) + N_TMR)) wr_ok = 1'b1;
    else if (aw_word_r >= 10'(OFS_DO >> 2) && aw_word_r < 10'((OFS_DO >> 2) + N_TMR)) wr_ok = 1'b1;
    else wr_ok = 1'b0;
  end
  // software registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      local_r <= SWITCH_RST;
      remote_r <= SWITCH_RST;
      tdur_r <= DELAY_RST;
      for (int i = 0; i < N_TMR; i++) begin
        pu_r[i] <= DELAY_RST;
        do_r[i] <= DELAY_RST;
      end
    end else if (wr_go && wr_ok) begin
      if (aw_word_r == 10'(OFS_LOCAL >> 2) && wstb_r[0]) local_r <= wdat_r[7:0];
      else if (aw_word_r == 10'(OFS_REMOTE >> 2) && wstb_r[0]) remote_r <= wdat_r[7:0];
      else if (aw_word_r == 10'(OFS_TDUR >> 2)) tdur_r <= wdat_r[15:0];
      for (int i = 0; i < N_TMR; i++) begin
        if (aw_word_r == 10'((OFS_PU >> 2) + i)) pu_r[i] <= wdat_r[15:0];
        if (aw_word_r == 10'((OFS_DO >> 2) + i)) do_r[i] <= wdat_r[15:0];
      end
    end
  end
  // equation store, not reset: software loads it before use
  always_ff @(posedge mclk) begin
    if (wr_go && wr_ok && aw_word_r >= 10'(OFS_EQ >> 2)) eq_mem[wr_eq[8:0]] <= wdat_r[10:0];
  end
  // target reset request, taken at the next trip step; a new request wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tgt_pend_r <= 1'b0;
    else if ((wr_go && aw_word_r == 10'(OFS_CTRL >> 2) && wdat_r[0]) || (pin_f_r[2] && !btn_prev_r))
      tgt_pend_r <= 1'b1;
    else if (st_r == ST_TRIP) tgt_pend_r <= 1'b0;
  end
  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  logic [9:0] rd_word, rd_eq;
  assign rd_word = s_axi_araddr[11:2];
  assign rd_eq = rd_word - 10'(OFS_EQ >> 2);
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0;
      if (rd_word >= 10'(OFS_EQ >> 2)) begin
        if (!rd_eq[9] && rd_eq[8:4] < 5'(N_EQ) && rd_eq[3:0] < 4'(N_SLOT))
          s_axi_rdata <= {21'h0, eq_mem[rd_eq[8:0]]};
        else s_axi_rresp <= RESP_SLVERR;
      end else if (rd_word == 10'(OFS_CTRL >> 2)) s_axi_rdata <= {31'h0, tgt_pend_r};
      else if (rd_word == 10'(OFS_LOCAL >> 2)) s_axi_rdata <= {24'h0, local_r};
      else if (rd_word == 10'(OFS_REMOTE >> 2)) s_axi_rdata <= {24'h0, remote_r};
      else if (rd_word == 10'(OFS_TDUR >> 2)) s_axi_rdata <= {16'h0, tdur_r};
      else if (rd_word == 10'(OFS_STAT >> 2))
        s_axi_rdata <= {4'h0, st_r == ST_IDLE, variable_timer_output, logic_variable, trip_output_bit};
      else if (rd_word >= 10'(OFS_PU >> 2) && rd_word < 10'((OFS_PU >> 2) + N_TMR))
        s_axi_rdata <= {16'h0, pu_r[4'(rd_word - 10'(OFS_PU >> 2))]};
      else if (rd_word >= 10'(OFS_DO >> 2) && rd_word < 10'((OFS_DO >> 2) + N_TMR))
        s_axi_rdata <= {16'h0, do_r[4'(rd_word - 10'(OFS_DO >> 2))]};
      else s_axi_rresp <= RESP_SLVERR;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
  // ----------------------------------------
  // logic point vector and tick divider
  // ----------------------------------------
  localparam int unsigned PT_W = 47 + ELEM_W;
  logic [255:0] pts;
  logic [N_TRIP-1:0] trip_r, tr_r, tr_prev_r, ul_r;
  logic [N_VAR-1:0] sv_r;
  logic [N_TMR-1:0] svt_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  // index 0 reads zero, index 1 reads one
  assign pts = {(256 - PT_W)'(0), svt_r, sv_r, trip_r, elem_bits, pin_f_r[1:0], remote_r, local_r,
                2'b10};
  assign tick = tick_cnt_r == 32'(TICK_COUNT - 1);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tick_cnt_r <= 32'h0;
    else if (tick) tick_cnt_r <= 32'h0;
    else tick_cnt_r <= tick_cnt_r + 32'h1;
  end
  // ----------------------------------------
  // equation sequencer: one operand slot per clock
  // ----------------------------------------
  logic [4:0] eq_r;
  logic [3:0] slot_r;
  logic sum_r, prod_r, have_r;
  logic [10:0] slot_w;
  logic opv, prod_n, sum_n, res;
  assign slot_w = eq_mem[{eq_r, slot_r}];
  // inversion binds to one operand, and before or
  always_comb begin
    opv = pts[slot_w[7:0]] ^ slot_w[SLOT_INV];
    prod_n = prod_r;
    sum_n = sum_r;
    if (slot_w[SLOT_EN]) begin
      if (slot_w[SLOT_OR] && have_r) begin
        sum_n = sum_r | prod_r;
        prod_n = opv;
      end else prod_n = have_r ? (prod_r & opv) : opv;
    end
    res = sum_n | ((have_r | slot_w[SLOT_EN]) & prod_n);
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
      eq_r <= 5'h0;
      slot_r <= 4'h0;
      {sum_r, prod_r, have_r} <= 3'b000;
      tr_r <= '0;
      ul_r <= '0;
      sv_r <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          eq_r <= 5'h0;
          slot_r <= 4'h0;
          {sum_r, prod_r, have_r} <= 3'b000;
          if (tick) st_r <= ST_EVAL;
        end
        ST_EVAL: begin
          {sum_r, prod_r} <= {sum_n, prod_n};
          have_r <= have_r | slot_w[SLOT_EN];
          slot_r <= slot_r + 4'h1;
          if (slot_r == 4'(N_SLOT - 1)) begin
            slot_r <= 4'h0;
            {sum_r, prod_r, have_r} <= 3'b000;
            eq_r <= eq_r + 5'h1;
            if (eq_r < 5'(N_TRIP)) tr_r[eq_r[1:0]] <= res;
            else if (eq_r < 5'(EQ_SV0)) ul_r[2'(eq_r - 5'(N_TRIP))] <= res;
            else sv_r[4'(eq_r - 5'(EQ_SV0))] <= res;
            // trips settle before the variables are written
            if (eq_r == 5'(EQ_SV0 - 1)) st_r <= ST_TRIP;
            if (eq_r == 5'(N_EQ - 1)) st_r <= ST_TIMR;
          end
        end
        ST_TRIP: st_r <= ST_EVAL;
        ST_TIMR: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // trip channels
  // ----------------------------------------
  logic [15:0] tdur_ticks;
  logic [15:0] dur_cnt_r [N_TRIP];
  assign tdur_ticks = to_ticks(tdur_r);
  for (genvar c = 0; c < N_TRIP; c++) begin : g_trip
    logic start;
    logic [15:0] cnt_n;
    logic unl;
    assign start = tr_r[c] && !tr_prev_r[c] && dur_cnt_r[c] == 16'h0;
    assign cnt_n = start ? tdur_ticks : (dur_cnt_r[c] != 16'h0 ? dur_cnt_r[c] - 16'h1 : 16'h0);
    assign unl = ul_r[c] || tgt_pend_r;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        trip_r[c] <= 1'b0;
        tr_prev_r[c] <= 1'b0;
        dur_cnt_r[c] <= 16'h0;
      end else if (st_r == ST_TRIP) begin
        tr_prev_r[c] <= tr_r[c];
        dur_cnt_r[c] <= cnt_n;
        // condition or duration sets; only unlatch releases a held trip
        trip_r[c] <= tr_r[c] || cnt_n != 16'h0 || (trip_r[c] && !unl);
      end
    end
    chk_trip_set: assert property (@(posedge mclk) disable iff (!rst_n)
      st_r == ST_TRIP && tr_r[c] |=> trip_r[c]) else $error("trip not set by condition");
    chk_trip_latch: assert property (@(posedge mclk) disable iff (!rst_n)
      $fell(trip_r[c]) |-> $past(!tr_r[c] && dur_cnt_r[c] <= 16'h1 && unl))
      else $error("trip released while held");
    chk_dur_noretrig: assert property (@(posedge mclk) disable iff (!rst_n)
      st_r == ST_TRIP && dur_cnt_r[c] > 16'h1 |=> dur_cnt_r[c] == $past(dur_cnt_r[c]) - 16'h1)
      else $error("duration timer retriggered");
  end
  // ----------------------------------------
  // variable timers on variables five to fourteen
  // ----------------------------------------
  for (genvar t = 0; t < N_TMR; t++) begin : g_tmr
    logic [15:0] cnt_r;
    logic in_b;
    logic [15:0] dly;
    assign in_b = sv_r[t + N_VAR - N_TMR];
    assign dly = in_b ? to_ticks(pu_r[t]) : to_ticks(do_r[t]);
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        svt_r[t] <= 1'b0;
        cnt_r <= 16'h0;
      end else if (st_r == ST_TIMR) begin
        if (in_b == svt_r[t]) cnt_r <= 16'h0;
        else if (cnt_r >= dly) begin
          svt_r[t] <= in_b;
          cnt_r <= 16'h0;
        end else cnt_r <= cnt_r + 16'h1;
      end
    end
    chk_tmr_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      st_r == ST_TIMR && dly == 16'h0 |=> svt_r[t] == $past(in_b))
      else $error("zero delay timer did not follow");
  end
  // ----------------------------------------
  // outputs and pass checks
  // ----------------------------------------
  assign trip_output_bit = trip_r;
  assign logic_variable = sv_r;
  assign variable_timer_output = svt_r;
  chk_pass_start: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(st_r == ST_EVAL) && $past(st_r == ST_IDLE) |-> $past(tick))
    else $error("pass began without tick");
  chk_trip_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(st_r == ST_TRIP) |-> $stable(trip_r)) else $error("trip changed outside its step");
  chk_trip_order: assert property (@(posedge mclk) disable iff (!rst_n)
    st_r == ST_TRIP |-> eq_r == 5'(EQ_SV0) && $stable(sv_r)) else $error("trip step out of order");
  chk_slot_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    slot_r < 4'(N_SLOT)) else $error("operand slot beyond nine");
  chk_tmr_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(st_r == ST_TIMR) |-> $stable(svt_r)) else $error("timer changed outside its step");
endmodule

/* verif/rlscan_far_model.sv */
// far-side model: protection elements, opto pins and the target reset pushbutton
module rlscan_far_model
  import rlscan_pkg::*;
#(
  parameter int unsigned ELEM_W = 64,
  parameter int unsigned PRESS_CYC = 12
) (
  // clock
  input wire logic mclk,
  // requests from the bench
  input wire logic [ELEM_W-1:0] elem_req,
  input wire logic [1:0] opto_req,
  input wire logic press_req,
  // pins toward the block
  output logic [ELEM_W-1:0] elem_bits,
  output logic [1:0] opto_in,
  output logic target_btn
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned hold_cnt;
  logic press_d;
  // everything starts released
  initial begin
    elem_bits = '0;
    opto_in = 2'b00;
    target_btn = 1'b0;
    hold_cnt = 0;
    press_d = 1'b0;
  end
  // element bits and opto levels follow the requests one clock later
  always @(posedge mclk) begin
    elem_bits <= elem_req;
    opto_in <= opto_req;
  end
  // an operator press lasts far longer than the pin filter needs
  always @(posedge mclk) begin
    press_d <= press_req;
    if (press_req && !press_d) begin
      hold_cnt <= PRESS_CYC;
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end
    target_btn <= (hold_cnt != 0);
  end
endmodule

/* verif/tb_relay_logic_scan_and_trip_latch.sv */
// self-checking bench for the relay logic scan and trip latch
module tb_relay_logic_scan_and_trip_latch
  import rlscan_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PT = 84; // first trip point, elements occupy 20..83
  localparam int LIMIT = 60000;
  logic mclk, nrst, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, press, btn;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, rd;
  logic [3:0] wst;
  logic [1:0] br, rr, rs, opto_q, opto;
  logic [63:0] elem_q, elem;
  logic [N_TRIP-1:0] trip;
  logic [N_VAR-1:0] vars;
  logic [N_TMR-1:0] tmr;
  int n_mismatch, compares, cyc;

  rlscan_top #(.TICK_COUNT(300), .ELEM_W(64)) DUT (
    .mclk(mclk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .elem_bits(elem),
    .opto_in(opto), .target_btn(btn), .trip_output_bit(trip), .logic_variable(vars),
    .variable_timer_output(tmr));
  rlscan_far_model #(.ELEM_W(64), .PRESS_CYC(12)) far (
    .mclk(mclk), .elem_req(elem_q), .opto_req(opto_q), .press_req(press), .elem_bits(elem),
    .opto_in(opto), .target_btn(btn));

  // clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // write: offer address and data together, release each when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    while (!(da && dw)) begin
      @(negedge mclk);
      ta = awv && awr;
      tw = wv && wrd;
      @(posedge mclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    do @(negedge mclk); while (!bv);
    rs = br;
    @(posedge mclk);
    bry <= 1'b0;
  endtask
  task automatic rdr(input logic [11:0] a);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(negedge mclk); while (!arr);
    @(posedge mclk);
    arv <= 1'b0;
    do @(negedge mclk); while (!rv);
    rd = rdat;
    rs = rr;
    @(posedge mclk);
    rry <= 1'b0;
  endtask
  function automatic logic [31:0] sl(input logic orn, input logic inv, input int idx);
    return {21'h0, 1'b1, orn, inv, idx[7:0]};
  endfunction
  task automatic slot(input int eq, input int s, input logic [31:0] w);
    wr(OFS_EQ + 12'((eq * 16 + s) * 4), w);
  endtask
  // one whole pass: wait for busy, then for idle again
  task automatic wait_pass();
    do rdr(OFS_STAT); while (rd[27] === 1'b1);
    do rdr(OFS_STAT); while (rd[27] !== 1'b1);
  endtask
  // set elements while idle, then let one pass see them
  task automatic step(input logic [63:0] e);
    @(posedge mclk);
    elem_q <= e;
    wait_pass();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdr(OFS_LOCAL);
    check(rd, {24'h0, SWITCH_RST}, "local switch reset");
    rdr(OFS_PU);
    check(rd, {16'h0, DELAY_RST}, "pickup reset");
    rdr(12'h020);
    check({rd[29:0], rs}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(12'h020, 32'h1);
    check(rs, RESP_SLVERR, "unmapped write");
    rdr(12'hc00);
    check(rs, RESP_SLVERR, "aliased slot read");
    wst <= 4'h0;
    wr(OFS_LOCAL, 32'h1);
    wst <= 4'hf;
    rdr(OFS_LOCAL);
    check(rd, 32'h0, "strobe off write");
    wr(OFS_TDUR, 32'h5);
    check(rs, RESP_OKAY, "mapped write");
    rdr(OFS_TDUR);
    check(rd, 32'h5, "duration readback");
    for (int e = 0; e < 20; e++) for (int s = 0; s < 9; s++) slot(e, s, 32'h0);
    wait_pass();
    wait_pass();
    check({trip, vars, tmr}, 27'h0, "empty equations");
  endtask
  // variables over elements, optos and switches; fixed test vectors
  task automatic t_eq();
    logic [8:0] ev[4] = '{9'h000, 9'h1fd, 9'h1ff, 9'h003};
    logic [3:0] ex[4] = '{4'h0, 4'hd, 4'hb, 4'h0};
    slot(6, 0, sl(0, 0, 20));
    slot(6, 1, sl(0, 1, 21));
    slot(6, 2, sl(1, 0, 22));
    for (int s = 0; s < 9; s++) slot(7, s, sl(0, 0, 20 + s));
    slot(8, 0, sl(0, 0, 18));
    slot(9, 0, sl(0, 0, 2));
    slot(9, 1, sl(1, 0, 10));
    wait_pass();
    for (int i = 0; i < 4; i++) begin
      wr(OFS_LOCAL, {31'h0, i == 1});
      wr(OFS_REMOTE, {31'h0, i == 2});
      opto_q <= {1'b0, i == 1};
      step({55'h0, ev[i]});
      check(vars[3:0], ex[i], "equation result");
    end
  endtask
  // trip on a variable sees it one pass late
  task automatic t_delay();
    slot(0, 0, sl(0, 0, PT + 3));
    slot(3, 0, sl(0, 0, 1));
    wr(OFS_TDUR, 32'h0);
    wait_pass();
    step(64'h1);
    check({vars[0], trip[0]}, 2'b10, "variable before trip");
    step(64'h1);
    check(trip[0], 1'b1, "trip asserted");
    step(64'h0);
    check(trip[0], 1'b1, "old variable value");
    step(64'h0);
    check(trip[0], 1'b0, "unlatched");
  endtask
  // minimum duration of 8 sixteenths is 4 ticks; a retrigger at pass 2 would hold to pass 5
  task automatic t_dur();
    wr(OFS_TDUR, 32'h8);
    slot(1, 0, sl(0, 0, 23));
    slot(4, 0, sl(0, 0, 1));
    wait_pass();
    for (int i = 0; i < 10; i++) begin
      step((i == 0 || i == 2) ? 64'h8 : 64'h0);
      if (i < 4) check(trip[1], 1'b1, "held by duration");
      else check(trip[1], 1'b0, "no retrigger");
    end
    for (int i = 0; i < 12; i++) step(64'h8);
    check(trip[1], 1'b1, "follows condition");
    step(64'h0);
    check(trip[1], 1'b0, "drops at once");
    wr(OFS_TDUR, 32'h0);
  endtask
  // latch released by equation, pushbutton and command
  task automatic t_latch();
    slot(2, 0, sl(0, 0, 25));
    slot(5, 0, sl(0, 0, 26));
    wait_pass();
    step(64'h20);
    step(64'h0);
    step(64'h0);
    check(trip[2], 1'b1, "stays latched");
    step(64'h60);
    check(trip[2], 1'b1, "condition wins");
    step(64'h40);
    check(trip[2], 1'b0, "unlatch equation");
    step(64'h20);
    step(64'h0);
    press <= 1'b1;
    step(64'h0);
    check(trip[2], 1'b0, "pushbutton");
    press <= 1'b0;
    step(64'h20);
    step(64'h0);
    check(trip[2], 1'b1, "latched again");
    wr(OFS_CTRL, 32'h1);
    step(64'h0);
    check(trip[2], 1'b0, "reset command");
  endtask
  // timers: 3 rounds to 2 ticks pickup, 4 gives 2 ticks dropout, zero acts at once
  task automatic t_tmr();
    logic [1:0] ex[6] = '{2'b10, 2'b10, 2'b11, 2'b01, 2'b01, 2'b00};
    wr(OFS_PU, 32'h3);
    wr(OFS_DO, 32'h4);
    slot(10, 0, sl(0, 0, 24));
    slot(11, 0, sl(0, 0, 24));
    wait_pass();
    for (int i = 0; i < 6; i++) begin
      step(i < 3 ? 64'h10 : 64'h0);
      check(tmr[1:0], ex[i], "variable timers");
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {awv, wv, bry, arv, rry, press} = 6'h0;
    {awa, ara, wd} = '0;
    wst = 4'hf;
    elem_q = '0;
    opto_q = 2'b00;
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    nrst = 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_eq();
    t_delay();
    t_dur();
    t_latch();
    t_tmr();
    give_verdict();
  end
endmodule
